// >>> rtl/dcr_ctrl.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dcr_ctrl
	import dcr_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	dcr_link_if.ctrl link
);
	typedef enum logic [1:0] {ST_IDLE, ST_PRE_WAIT, ST_RD_WAIT} dcr_state_t;

	dcr_state_t state_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [1:0] ctrl_q;
	logic [31:0] cmd_q;
	logic cmd_pend_q;
	logic refused_q;
	logic ro_q;
	logic sref_q;
	logic temp_sel_q;
	logic [15:0] rdata_q;
	logic [8:0] refi_cnt_q;
	logic ref_due_q;
	logic [7:0] wait_q;
	logic [15:0] dq_s1_q;
	logic [15:0] dq_s2_q;
	logic oe_s1_q;
	logic oe_s2_q;
	logic slot;
	logic do_wr;
	logic wr_cmd;
	logic cmd_ok;
	logic take;
	logic op_refused;
	logic mem_rst;
	dcr_op_t op;

	assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_cmd = do_wr && awaddr_q == OFS_CMD && wstrb_q == 4'hF;
	assign cmd_ok = wr_cmd && !cmd_pend_q && state_q == ST_IDLE;
	// Outputs change as ck falls, except reset_n and the memory reset branch, so the DRAM sees them settled
	assign slot = link.ck;
	assign mem_rst = ctrl_q[CTRL_RST_BIT];
	assign op = dcr_op_t'(cmd_q[CMD_OP_LSB +: 3]);
	assign take = slot && state_q == ST_IDLE && cmd_pend_q && !mem_rst
		&& !(ref_due_q && !ro_q && !sref_q);
	// Readout mode allows only reads and its exit
	assign op_refused = (ro_q && op != OP_READ && op != OP_EXIT_RO)
		|| (sref_q && op != OP_SREF_EXIT) || op == OP_NONE;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			link.ck <= 1'b0;
		else
			link.ck <= !link.ck;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_CMD)
					? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			ctrl_q <= CTRL_RESET;
		else if (do_wr && awaddr_q == OFS_CTRL && wstrb_q[0])
			ctrl_q <= wdata_q[1:0];
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			cmd_pend_q <= 1'b0;
			cmd_q <= 32'h00000000;
		end
		else if (cmd_ok)
		begin
			cmd_pend_q <= 1'b1;
			cmd_q <= wdata_q;
		end
		else if (take || mem_rst)
			cmd_pend_q <= 1'b0;
	end

	// A refusal in the same cycle as an accepted order still shows
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			refused_q <= 1'b0;
		else if ((wr_cmd && !cmd_ok) || (take && op_refused))
			refused_q <= 1'b1;
		else if (cmd_ok)
			refused_q <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			case (s_axi_araddr)
				OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_q};
				OFS_CMD: s_axi_rdata <= cmd_q;
				OFS_STAT: s_axi_rdata <= {27'h0, temp_sel_q, sref_q, refused_q,
					ro_q, cmd_pend_q || state_q != ST_IDLE};
				OFS_RDATA: s_axi_rdata <= {16'h0, rdata_q};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Refresh pacing; a due refresh waits out readout and self refresh
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			refi_cnt_q <= 9'h000;
			ref_due_q <= 1'b0;
		end
		else
		begin
			if (refi_cnt_q == 9'h000)
			begin
				refi_cnt_q <= ctrl_q[CTRL_EXT_BIT]
					? 9'(REFI_EXT_CYC - 1) : 9'(REFI_NORM_CYC - 1);
				ref_due_q <= 1'b1;
			end
			else
			begin
				refi_cnt_q <= refi_cnt_q - 9'h001;
				if (slot && state_q == ST_IDLE && ref_due_q && !ro_q
					&& !sref_q && !mem_rst)
					ref_due_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			oe_s1_q <= 1'b0;
			oe_s2_q <= 1'b0;
		end
		else
		begin
			dq_s1_q <= link.dq;
			dq_s2_q <= dq_s1_q;
			oe_s1_q <= link.dq_oe_dev;
			oe_s2_q <= oe_s1_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= ST_IDLE;
			ro_q <= 1'b0;
			sref_q <= 1'b0;
			temp_sel_q <= 1'b0;
			rdata_q <= 16'h0000;
			wait_q <= 8'h00;
			link.reset_n <= 1'b0;
			link.cke <= 1'b0;
			link.cs_n <= 1'b1;
			{link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
			link.ba <= 3'h0;
			link.addr <= 13'h0000;
			link.dq_o_ctl <= 16'h0000;
			link.dq_oe_ctl <= 1'b0;
		end
		else if (mem_rst)
		begin
			state_q <= ST_IDLE;
			ro_q <= 1'b0;
			sref_q <= 1'b0;
			temp_sel_q <= 1'b0;
			link.reset_n <= 1'b0;
			link.cke <= 1'b0;
			link.cs_n <= 1'b1;
			link.dq_oe_ctl <= 1'b0;
		end
		else
		begin
			link.reset_n <= 1'b1;
			if (wait_q != 8'h00)
				wait_q <= wait_q - 8'h01;
			if (state_q == ST_RD_WAIT && oe_s2_q)
			begin
				rdata_q <= dq_s2_q;
				state_q <= ST_IDLE;
			end
			if (slot)
			begin
				link.cs_n <= 1'b1;
				{link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
				link.dq_oe_ctl <= 1'b0;
				link.cke <= !sref_q;
				if (state_q == ST_PRE_WAIT && wait_q == 8'h00)
				begin
					link.cs_n <= 1'b0;
					{link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
					link.ba <= BA_MODE3;
					link.addr <= 13'h0004;
					ro_q <= 1'b1;
					state_q <= ST_IDLE;
				end
				else if (state_q == ST_IDLE && ref_due_q && !ro_q && !sref_q)
				begin
					link.cs_n <= 1'b0;
					{link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
				end
				else if (take && !op_refused)
				begin
					link.cs_n <= 1'b0;
					link.addr <= cmd_q[CMD_ADDR_LSB +: 13];
					case (op)
						OP_ENTER_RO:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
							link.addr <= 13'h0400;
							wait_q <= 8'(PRECHARGE_CYC);
							state_q <= ST_PRE_WAIT;
						end
						OP_EXIT_RO:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
							link.ba <= BA_MODE3;
							link.addr <= 13'h0000;
							ro_q <= 1'b0;
						end
						OP_READ:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_RD;
							state_q <= ST_RD_WAIT;
						end
						OP_WRITE:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_WR;
							link.dq_o_ctl <= cmd_q[15:0];
							link.dq_oe_ctl <= 1'b1;
						end
						OP_SET_TEMP:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_MRS;
							link.ba <= BA_MODE2;
							link.addr <= {5'h00, cmd_q[0], 7'h00};
							temp_sel_q <= cmd_q[0];
						end
						OP_SREF_ENTER:
						begin
							{link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
							link.cke <= 1'b0;
							sref_q <= 1'b1;
						end
						OP_SREF_EXIT:
						begin
							link.cs_n <= 1'b1;
							link.cke <= 1'b1;
							sref_q <= 1'b0;
						end
						default:
							link.cs_n <= 1'b1;
					endcase
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> rtl/dcr_dram.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_dram
	import dcr_pkg::*;
(
	dcr_link_if.dram link,
	output logic readout_active,
	output logic self_refresh,
	output logic sref_rate_2x,
	output logic violation
);
	logic [2:0] cmd;
	logic sel;
	logic cke_prev_q;
	logic [1:0] loc_q;
	logic [15:0] mem [16];
	logic [READ_LAT_CK-1:0] pv_q;
	logic [15:0] pd_q [READ_LAT_CK];
	logic [15:0] rd_word;
	logic [1:0] oe_cnt_q;

	assign sel = !link.cs_n && link.cke;
	assign cmd = {link.ras_n, link.cas_n, link.we_n};
	// Location bits only matter while readout is on
	assign rd_word = readout_active ? pattern_word(loc_q)
		: mem[link.addr[3:0]];

	// Async reset pin clears mode state in any mode
	always_ff @(posedge link.ck or negedge link.reset_n)
	begin
		if (!link.reset_n)
		begin
			readout_active <= 1'b0;
			loc_q <= 2'h0;
			sref_rate_2x <= 1'b0;
		end
		else if (sel && cmd == CMD_MRS && link.ba == BA_MODE3)
		begin
			readout_active <= link.addr[MODE3_RO_BIT];
			loc_q <= link.addr[1:0];
		end
		else if (sel && cmd == CMD_MRS && link.ba == BA_MODE2)
			sref_rate_2x <= link.addr[MODE2_TEMP_BIT];
	end

	always_ff @(posedge link.ck or negedge link.reset_n)
	begin
		if (!link.reset_n)
		begin
			self_refresh <= 1'b0;
			cke_prev_q <= 1'b1;
		end
		else
		begin
			cke_prev_q <= link.cke;
			if (cke_prev_q && !link.cke && !link.cs_n && cmd == CMD_REF)
				self_refresh <= 1'b1;
			else if (link.cke)
				self_refresh <= 1'b0;
		end
	end

	// Flags controller misuse; the mode itself is not blocked
	always_ff @(posedge link.ck or negedge link.reset_n)
	begin
		if (!link.reset_n)
			violation <= 1'b0;
		else if (readout_active && ((sel && cmd != CMD_RD && cmd != CMD_NOP
			&& cmd != CMD_MRS) || !link.cke))
			violation <= 1'b1;
	end

	// Array writes are dropped in readout mode
	always_ff @(posedge link.ck)
	begin
		if (sel && cmd == CMD_WR && !readout_active)
			mem[link.addr[3:0]] <= link.dq;
	end

	always_ff @(posedge link.ck or negedge link.reset_n)
	begin
		if (!link.reset_n)
			pv_q <= '0;
		else
			pv_q <= {pv_q[READ_LAT_CK-2:0], sel && cmd == CMD_RD};
	end

	always_ff @(posedge link.ck)
	begin
		pd_q[0] <= rd_word;
		for (int i = 1; i < READ_LAT_CK; i++)
			pd_q[i] <= pd_q[i-1];
	end

	always_ff @(posedge link.ck or negedge link.reset_n)
	begin
		if (!link.reset_n)
		begin
			link.dq_o_dev <= 16'h0000;
			link.dq_oe_dev <= 1'b0;
			oe_cnt_q <= 2'h0;
		end
		else if (pv_q[READ_LAT_CK-1])
		begin
			link.dq_o_dev <= pd_q[READ_LAT_CK-1];
			link.dq_oe_dev <= 1'b1;
			oe_cnt_q <= READ_OE_CK - 2'h1;
		end
		else if (oe_cnt_q != 2'h0)
			oe_cnt_q <= oe_cnt_q - 2'h1;
		else
			link.dq_oe_dev <= 1'b0;
	end
endmodule
`default_nettype wire

// >>> rtl/dcr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dcr_link_if;
	logic ck;
	logic reset_n;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [2:0] ba;
	logic [12:0] addr;
	logic [15:0] dq_o_ctl;
	logic dq_oe_ctl;
	logic [15:0] dq_o_dev;
	logic dq_oe_dev;
	logic [15:0] dq;

	assign dq = dq_oe_dev ? dq_o_dev : (dq_oe_ctl ? dq_o_ctl : 16'h0000);

	modport ctrl (output ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba,
		addr, dq_o_ctl, dq_oe_ctl, input dq, dq_oe_dev);
	modport dram (input ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, ba,
		addr, dq, output dq_o_dev, dq_oe_dev);
endinterface
`default_nettype wire

// >>> rtl/dcr_pkg.sv
package dcr_pkg;
	localparam int CLK_SYS_MHZ = 40;
	localparam int PRECHARGE_NS = 15;
	localparam int PRECHARGE_RAW = (PRECHARGE_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int PRECHARGE_CYC = (PRECHARGE_RAW < 1) ? 1 : PRECHARGE_RAW;
	localparam int REFI_NORM_NS = 7800;
	localparam int REFI_EXT_NS = 3900;
	localparam int REFI_NORM_CYC = REFI_NORM_NS * CLK_SYS_MHZ / 1000;
	localparam int REFI_EXT_CYC = REFI_EXT_NS * CLK_SYS_MHZ / 1000;
	localparam int READ_LAT_CK = 5;
	localparam logic [1:0] READ_OE_CK = 2'h2;
	// Command encodings on {ras_n, cas_n, we_n}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] BA_MODE2 = 3'h2;
	localparam logic [2:0] BA_MODE3 = 3'h3;
	localparam int MODE3_RO_BIT = 2;
	localparam int MODE2_TEMP_BIT = 7;
	localparam int AP_BIT = 10;
	// Register offsets and fields
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CMD = 4'h4;
	localparam logic [3:0] OFS_STAT = 4'h8;
	localparam logic [3:0] OFS_RDATA = 4'hC;
	localparam int CTRL_EXT_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam int CMD_OP_LSB = 29;
	localparam int CMD_ADDR_LSB = 16;
	localparam int STAT_BUSY = 0;
	localparam int STAT_RO = 1;
	localparam int STAT_REFUSED = 2;
	localparam int STAT_SREF = 3;
	localparam int STAT_TEMP = 4;
	localparam logic [15:0] PATTERN_LOC0 = 16'h00FF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {OP_ENTER_RO, OP_EXIT_RO, OP_READ, OP_WRITE,
		OP_SET_TEMP, OP_SREF_ENTER, OP_SREF_EXIT, OP_NONE} dcr_op_t;

	function automatic logic [15:0] pattern_word(input logic [1:0] loc);
		pattern_word = (loc == 2'h0) ? PATTERN_LOC0 : 16'h0000;
	endfunction
endpackage

// >>> tb/dcr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_properties
	import dcr_pkg::*;
(
	input wire logic ck,
	input wire logic reset_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [2:0] ba,
	input wire logic [12:0] addr,
	input wire logic [15:0] dq_o_dev,
	input wire logic dq_oe_dev
);
	default clocking cb @(posedge ck); endclocking
	default disable iff (!reset_n);
	logic [2:0] cmd;
	logic issue, mrs3, ro_q, pre_q, rdro_q;
	logic [1:0] loc_q;
	assign cmd = {ras_n, cas_n, we_n};
	assign issue = cke && !cs_n;
	assign mrs3 = issue && cmd == CMD_MRS && ba == BA_MODE3;
	// Device reset drops the mode, so helpers follow it
	always_ff @(posedge ck or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ro_q <= 1'b0;
			loc_q <= 2'h0;
		end
		else if (mrs3)
		begin
			ro_q <= addr[MODE3_RO_BIT];
			loc_q <= addr[1:0];
		end
	end
	always_ff @(posedge ck or negedge reset_n)
	begin
		if (!reset_n)
			pre_q <= 1'b0;
		else if (issue && cmd == CMD_PRE && addr[AP_BIT])
			pre_q <= 1'b1;
		else if (issue && (cmd == CMD_RD || cmd == CMD_WR))
			pre_q <= 1'b0;
	end
	always_ff @(posedge ck or negedge reset_n)
	begin
		if (!reset_n)
			rdro_q <= 1'b0;
		else if (issue && cmd == CMD_RD)
			rdro_q <= ro_q;
	end
	property p_enter_pre;
		mrs3 && addr[MODE3_RO_BIT] |-> pre_q;
	endproperty
	a_enter_pre: assert property (p_enter_pre)
		else $error("enter unprecharged");
	property p_ro_cmds;
		ro_q && issue |-> cmd == CMD_RD || mrs3;
	endproperty
	a_ro_cmds: assert property (p_ro_cmds)
		else $error("bad readout cmd");
	property p_ro_cke;
		ro_q |-> cke;
	endproperty
	a_ro_cke: assert property (p_ro_cke)
		else $error("cke low in readout");
	property p_rd_oe;
		issue && cmd == CMD_RD |-> ##[5:6] dq_oe_dev;
	endproperty
	a_rd_oe: assert property (p_rd_oe)
		else $error("read not answered");
	property p_pattern;
		dq_oe_dev && rdro_q |->
			dq_o_dev == ((loc_q == 2'h0) ? PATTERN_LOC0 : 16'h0000);
	endproperty
	a_pattern: assert property (p_pattern)
		else $error("bad pattern word");
	property p_oe_len;
		$rose(dq_oe_dev) |-> ##1 dq_oe_dev ##1 !dq_oe_dev;
	endproperty
	a_oe_len: assert property (p_oe_len)
		else $error("bad burst length");
	property p_mode3_ba;
		issue && cmd == CMD_MRS && ba[1:0] == 2'h3 |->
			!ba[2] && addr[12:3] == 10'h0;
	endproperty
	a_mode3_ba: assert property (p_mode3_ba)
		else $error("bad mode three write");
	property p_exit_loc;
		mrs3 && !addr[MODE3_RO_BIT] |-> addr[1:0] == 2'h0;
	endproperty
	a_exit_loc: assert property (p_exit_loc)
		else $error("bad exit bits");
	property p_temp_sel;
		issue && cmd == CMD_MRS && ba == BA_MODE2 |->
			addr[12:8] == 5'h0 && addr[6:0] == 7'h0;
	endproperty
	a_temp_sel: assert property (p_temp_sel)
		else $error("bad mode two write");
	c_enter: cover property (mrs3 && addr[MODE3_RO_BIT]);
	c_pat: cover property (dq_oe_dev && rdro_q);
	c_ref: cover property (issue && cmd == CMD_REF);
endmodule
`default_nettype wire

// >>> tb/ddr3_calibration_readout_mode_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin \
	n_errors++; $display("[ERR] %s exp %h seen %h", n, e, s); end end
module ddr3_calibration_readout_mode_test
	import dcr_pkg::*;
;
	logic clk_sys, rstn, awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic [3:0] awa, ara, ws;
	logic [31:0] wd, rdat, last_rd, v;
	logic [1:0] bresp, rresp, e2;
	logic [65:0] er;
	logic dev_ro, dev_sr, dev_2x, dev_viol;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	int n_errors, checks_done, seed, i, d, e;
	time t0, t1;
	dcr_link_if link();
	dcr_ctrl i_dcr_ctrl(.clk_sys(clk_sys), .rstn(rstn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .link(link));
	dcr_dram i_dcr_dram(.link(link), .readout_active(dev_ro),
		.self_refresh(dev_sr), .sref_rate_2x(dev_2x), .violation(dev_viol));
	dcr_properties i_dcr_properties(.ck(link.ck), .reset_n(link.reset_n),
		.cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
		.addr(link.addr), .dq_o_dev(link.dq_o_dev),
		.dq_oe_dev(link.dq_oe_dev));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic hang;
		n_errors++;
		stop_test();
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] dt,
		input logic [1:0] r);
		int k;
		bq.push_back(r);
		@(posedge clk_sys);
		awa <= a;
		wd <= dt;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge clk_sys);
			if (awr)
				awv <= 1'b0;
			if (wrd)
				wv <= 1'b0;
			if (bv)
				break;
		end
		br <= 1'b0;
		if (k == 100)
			hang();
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] x, input logic [1:0] r);
		int k;
		rq.push_back({m, r, x});
		@(posedge clk_sys);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge clk_sys);
			if (rv)
				break;
			if (arr)
				arv <= 1'b0;
		end
		last_rd = rdat;
		rr <= 1'b0;
		if (k == 100)
			hang();
	endtask
	task automatic poll;
		int k;
		for (k = 0; k < 200; k++)
		begin
			axr(OFS_STAT, 32'h0, 32'h0, RESP_OKAY);
			if (last_rd[STAT_BUSY] === 1'b0)
				break;
		end
		if (k == 200)
			hang();
	endtask
	task automatic cmd(input dcr_op_t op, input logic [12:0] a,
		input logic [15:0] dt);
		axw(OFS_CMD, {op, a, dt}, RESP_OKAY);
		poll();
		repeat (6) @(posedge clk_sys);
	endtask
	task automatic st(input int b, input logic x);
		axr(OFS_STAT, 32'h1 << b, 32'(x) << b, RESP_OKAY);
	endtask
	always @(posedge clk_sys)
	begin
		if (bv && br)
		begin
			e2 = bq.pop_front();
			`CHK("bresp", e2, bresp)
		end
		if (rv && rr)
		begin
			er = rq.pop_front();
			`CHK("rresp", er[33:32], rresp)
			`CHK("rdata", er[31:0], rdat & er[65:34])
		end
	end
	always @(posedge link.ck)
		if (link.cke && !link.cs_n
			&& {link.ras_n, link.cas_n, link.we_n} == CMD_REF)
		begin
			t0 <= t1;
			t1 <= $time;
		end
	initial
	begin
		seed = 32'h169b;
		{rstn, awv, wv, br, arv, rr} = 6'h0;
		{awa, ara, wd} = 40'h0;
		ws = 4'hF;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		poll();
		axr(OFS_CTRL, 32'h3, {30'h0, CTRL_RESET}, RESP_OKAY);
		// Partial strobe on the order register is dropped silently
		ws <= 4'h3;
		axw(OFS_CMD, {OP_READ, 13'h0, 16'h0}, RESP_OKAY);
		ws <= 4'hF;
		axr(OFS_STAT, 32'h1F, 32'h0, RESP_OKAY);
		axw(4'h6, 32'h0, RESP_SLVERR);
		axr(4'h6, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		$display("test reset and map done");
		for (i = 0; i < 4; i++)
		begin
			cmd(OP_ENTER_RO, 13'(i), 16'h0);
			st(STAT_RO, 1'b1);
			`CHK("dev_ro", 1'b1, dev_ro)
			cmd(OP_READ, 13'h5, 16'h0);
			// Entry always selects pattern location zero
			axr(OFS_RDATA, 32'hFFFF, {16'h0, PATTERN_LOC0}, RESP_OKAY);
			cmd(OP_WRITE, 13'h1, 16'h1234);
			st(STAT_REFUSED, 1'b1);
			cmd(OP_SREF_ENTER, 13'h0, 16'h0);
			st(STAT_SREF, 1'b0);
			cmd(OP_EXIT_RO, 13'h0, 16'h0);
			st(STAT_RO, 1'b0);
			`CHK("dev_ro", 1'b0, dev_ro)
		end
		$display("test readout done");
		for (i = 0; i < 3; i++)
		begin
			v = $random(seed);
			cmd(OP_WRITE, {9'h0, v[3:0]}, v[31:16]);
			cmd(OP_READ, {9'h0, v[3:0]}, 16'h0);
			axr(OFS_RDATA, 32'hFFFF, {16'h0, v[31:16]}, RESP_OKAY);
		end
		$display("test array done");
		cmd(OP_SET_TEMP, 13'h0, 16'h1);
		st(STAT_TEMP, 1'b1);
		`CHK("dev_2x", 1'b1, dev_2x)
		cmd(OP_SREF_ENTER, 13'h0, 16'h0);
		`CHK("dev_sr", 1'b1, dev_sr)
		cmd(OP_SREF_EXIT, 13'h0, 16'h0);
		`CHK("dev_sr", 1'b0, dev_sr)
		$display("test self refresh done");
		cmd(OP_ENTER_RO, 13'h0, 16'h0);
		axw(OFS_CTRL, 32'h2, RESP_OKAY);
		repeat (8) @(posedge clk_sys);
		`CHK("dev_ro", 1'b0, dev_ro)
		`CHK("dev_2x", 1'b0, dev_2x)
		st(STAT_RO, 1'b0);
		axw(OFS_CTRL, 32'h0, RESP_OKAY);
		poll();
		$display("test reset in readout done");
		for (i = 0; i < 2; i++)
		begin
			axw(OFS_CTRL, 32'(i), RESP_OKAY);
			repeat (800) @(posedge clk_sys);
			d = int'((t1 - t0) / 25);
			e = (i == 1) ? REFI_EXT_CYC : REFI_NORM_CYC;
			`CHK("refi", 1'b1, d > e - 3 && d < e + 3)
		end
		$display("test refresh interval done");
		`CHK("violation", 1'b0, dev_viol)
		stop_test();
	end
endmodule
`default_nettype wire
